//--- verilog/frg_pkg.sv
package frg_pkg;
    // flash map
    localparam logic [15:0] FRG_PROT_ADDR = 16'hFFDB;
    localparam logic [15:0] FRG_ID_ADDR = 16'hFFD4;
    localparam logic [15:0] FRG_BOOT_LO = 16'hF000;
    localparam int FRG_ID_LEN = 7;
    localparam logic [7:0] FRG_BLANK = 8'hFF;
    // protect control byte layout
    localparam int FRG_L1_BIT = 2;
    localparam int FRG_L2_BIT = 3;
    localparam int FRG_REL_LO = 6;
    localparam logic [1:0] FRG_REL_OFF = 2'h0;
    // pin filter
    localparam int FRG_SYNC = 3;
    localparam int FRG_NPIN = 6;
    localparam int FRG_PIN_BOOT = 0;
    localparam int FRG_PIN_RP = 1;
    localparam int FRG_PIN_CE = 2;
    localparam int FRG_PIN_SCLK = 3;
    localparam int FRG_PIN_SIN = 4;
    localparam int FRG_PIN_SOUT = 5;
    localparam logic [2:0] FRG_BIT_LAST = 3'h7;
    localparam logic [1:0] FRG_LVL_OFF = 2'h0;
    localparam logic [1:0] FRG_LVL1 = 2'h1;
    localparam logic [1:0] FRG_LVL2 = 2'h2;
    // register map, byte offsets
    localparam logic [7:0] FRG_REG_CTRL = 8'h00;
    localparam logic [7:0] FRG_REG_ADDR = 8'h04;
    localparam logic [7:0] FRG_REG_DATA = 8'h08;
    localparam logic [7:0] FRG_REG_STAT = 8'h0C;
    localparam logic [7:0] FRG_REG_RX = 8'h10;
    localparam logic [7:0] FRG_REG_TX = 8'h14;
    localparam int FRG_CTRL_GO = 0;
    localparam int FRG_CTRL_CMD = 1;
    localparam int FRG_HTRANS_ACT = 1;
    typedef enum logic [1:0] {
        FRG_READ = 2'h0,
        FRG_PROG = 2'h1,
        FRG_ERASE = 2'h2,
        FRG_CLEAR = 2'h3
    } frg_cmd_type;
    typedef enum logic [3:0] {
        ST_LOAD = 4'h1,
        ST_IDLE = 4'h2,
        ST_OP = 4'h4,
        ST_ANS = 4'h8
    } frg_state_type;
endpackage : frg_pkg

//--- verilog/frg_guard.sv
`timescale 1ns/1ps
// Overview of operation
// - any protect-enable bit at zero blocks parallel readout and modification
// - both levels requested means level 2 applies
// - level 2 also refuses readout on the factory test path
// - release bits at 00 switch protection off
// - while protected, parallel writes cannot change the release bits
// - serial mode, non-blank flash: identifier mismatch rejects all programmer commands
// - stored identifier is read from consecutive bytes at the identifier addresses
// - parallel writer presents command, address, data; device runs read, program, erase
// - an erase aimed at the boot area erases the whole 4 Kbyte block
// - boot-select high with the other straps set at reset starts serial mode
// - serial mode rewrites the user area only, never the boot area
// - serial mode rewrites run through the processor, data taken from the link
// - serial variant 1 is clocked synchronous, variant 2 unclocked asynchronous
// - in variant 1 the programmer clocks data in and out
// - in variant 1 the device drives a busy output
// - either error flag set refuses read, program, erase until clear-status
module frg_guard #(
    parameter int ID_LEN = frg_pkg::FRG_ID_LEN
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic BOOT_SELECT_PIN,
    input wire logic REWRITE_PROTECT_INPUT,
    input wire logic CHIP_ENABLE_INPUT,
    input wire logic SERIAL_CLOCK_PIN,
    input wire logic SERIAL_IN_PIN,
    input wire logic SERIAL_OUT_PIN_I,
    output logic SERIAL_OUT_PIN_O,
    output logic SERIAL_OUT_PIN_OE_N,
    output logic BUSY_PIN,
    output logic SERIAL_MODE,
    output logic [1:0] PROT_LEVEL,
    input wire logic PAR_REQ,
    input wire logic [1:0] PAR_CMD,
    input wire logic [15:0] PAR_ADDR,
    input wire logic [7:0] PAR_WDATA,
    input wire logic PAR_TEST,
    output logic PAR_ACK,
    output logic PAR_DENY,
    output logic [7:0] PAR_RDATA,
    output logic FL_REQ,
    output logic [1:0] FL_CMD,
    output logic [15:0] FL_ADDR,
    output logic [7:0] FL_WDATA,
    input wire logic FL_DONE,
    input wire logic [7:0] FL_RDATA,
    input wire logic FL_PROG_ERR,
    input wire logic FL_ERASE_ERR
);
    import frg_pkg::*;

    localparam int LDW = $clog2(ID_LEN + 1);

    function automatic logic in_boot(input logic [15:0] a);
        return a >= FRG_BOOT_LO;
    endfunction : in_boot

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // pins: three flops, a change counts once the last two agree
    logic [FRG_NPIN-1:0] pin_raw;
    logic [FRG_NPIN-1:0] pin_f;
    logic [FRG_NPIN-1:0] pin_q;
    assign pin_raw = {SERIAL_OUT_PIN_I, SERIAL_IN_PIN, SERIAL_CLOCK_PIN,
                      CHIP_ENABLE_INPUT, REWRITE_PROTECT_INPUT, BOOT_SELECT_PIN};
    genvar gi;
    generate
        for (gi = 0; gi < FRG_NPIN; gi++) begin : g_pin
            logic [FRG_SYNC-1:0] sh;
            logic filt;
            always_ff @(posedge CLK or negedge rst_n) begin
                if (!rst_n) begin
                    sh <= '0;
                    filt <= 1'h0;
                end else begin
                    sh <= {sh[FRG_SYNC-2:0], pin_raw[gi]};
                    if (sh[FRG_SYNC-1] == sh[FRG_SYNC-2]) begin
                        filt <= sh[FRG_SYNC-1];
                    end
                end
            end
            assign pin_f[gi] = filt;
        end
    endgenerate
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= '0;
        end else begin
            pin_q <= pin_f;
        end
    end
    wire sclk_rise = pin_f[FRG_PIN_SCLK] && !pin_q[FRG_PIN_SCLK];
    wire strap_ok = pin_f[FRG_PIN_BOOT] && !pin_f[FRG_PIN_RP] && pin_f[FRG_PIN_CE]
                    && !pin_f[FRG_PIN_SCLK] && pin_f[FRG_PIN_SOUT];

    ////////////////////////////////////////////////////////////////////////
    // protection decode from the loaded control byte
    logic [7:0] prot_byte;
    logic [7:0] id_mem [0:ID_LEN-1];
    wire rel_off = prot_byte[FRG_REL_LO +: 2] == FRG_REL_OFF;
    wire l1_sel = !prot_byte[FRG_L1_BIT];
    wire l2_sel = !prot_byte[FRG_L2_BIT];
    wire prot_on = !rel_off && (l1_sel || l2_sel);
    wire lvl2 = prot_on && l2_sel;
    logic blank;
    always_comb begin
        blank = 1'h1;
        for (int i = 0; i < ID_LEN; i++) begin
            blank = blank && (id_mem[i] == FRG_BLANK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    frg_state_type state;
    frg_state_type next_state;
    logic [LDW-1:0] ld_idx;
    logic serial_mode;
    logic cpu_go;
    logic [1:0] cpu_cmd;
    logic [15:0] cpu_addr;
    logic [7:0] cpu_wdata;
    logic [1:0] op_cmd;
    logic [15:0] op_addr;
    logic [7:0] op_wdata;
    logic [7:0] op_rdata;
    logic op_cpu;
    logic op_deny;
    logic last_deny;
    logic prog_err;
    logic erase_err;

    wire ld_last = ld_idx == LDW'(ID_LEN);
    wire [15:0] ld_addr = ld_last ? FRG_PROT_ADDR : FRG_ID_ADDR + 16'(ld_idx);
    wire take = state == ST_IDLE && (cpu_go || PAR_REQ);
    wire par_take = take && !cpu_go;
    wire [1:0] sel_cmd = cpu_go ? cpu_cmd : PAR_CMD;
    wire [15:0] sel_addr = cpu_go ? cpu_addr : PAR_ADDR;
    wire err_any = prog_err || erase_err;
    // parallel path: test-path reads survive level 1, not level 2
    wire par_rd_deny = prot_on && (!PAR_TEST || lvl2);
    wire par_blk = PAR_CMD == FRG_READ ? par_rd_deny : prot_on;
    wire par_deny = serial_mode || (PAR_CMD != FRG_CLEAR && (err_any || par_blk));
    // processor path ignores protection; in serial mode only the boot area, release bits included, is fenced
    wire cpu_boot = serial_mode && cpu_cmd != FRG_READ && in_boot(cpu_addr);
    wire cpu_deny = cpu_cmd != FRG_CLEAR && (err_any || cpu_boot);
    wire take_deny = cpu_go ? cpu_deny : par_deny;
    wire clr = take && sel_cmd == FRG_CLEAR && !take_deny;
    wire erase_boot = sel_cmd == FRG_ERASE && in_boot(sel_addr);
    wire op_done = state == ST_OP && FL_DONE;

    always_comb begin
        next_state = state;
        case (state)
            ST_LOAD: if (FL_DONE && ld_last) next_state = ST_IDLE;
            ST_IDLE: if (take) next_state = (take_deny || sel_cmd == FRG_CLEAR) ? ST_ANS : ST_OP;
            ST_OP: if (FL_DONE) next_state = ST_ANS;
            ST_ANS: next_state = ST_IDLE;
            default: next_state = ST_LOAD;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_LOAD;
            ld_idx <= '0;
            prot_byte <= FRG_BLANK;
            serial_mode <= 1'h0;
            for (int i = 0; i < ID_LEN; i++) begin
                id_mem[i] <= FRG_BLANK;
            end
        end else begin
            state <= next_state;
            if (state == ST_LOAD && FL_DONE) begin
                ld_idx <= LDW'(ld_idx + 1'h1);
                if (ld_last) begin
                    prot_byte <= FL_RDATA;
                    serial_mode <= strap_ok;
                end else begin
                    id_mem[ld_idx] <= FL_RDATA;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            op_cmd <= FRG_READ;
            op_addr <= 16'h0000;
            op_wdata <= 8'h00;
            op_cpu <= 1'h0;
            op_deny <= 1'h0;
        end else if (take) begin
            op_cmd <= sel_cmd;
            op_addr <= erase_boot ? FRG_BOOT_LO : sel_addr;
            op_wdata <= cpu_go ? cpu_wdata : PAR_WDATA;
            op_cpu <= cpu_go;
            op_deny <= take_deny;
        end
    end

    // error flags: a failure in the clearing cycle still sticks
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            prog_err <= 1'h0;
            erase_err <= 1'h0;
            op_rdata <= 8'h00;
            last_deny <= 1'h0;
        end else begin
            prog_err <= (op_done && FL_PROG_ERR) || (prog_err && !clr);
            erase_err <= (op_done && FL_ERASE_ERR) || (erase_err && !clr);
            if (op_done) begin
                op_rdata <= FL_RDATA;
            end
            if (state == ST_ANS && op_cpu) begin
                last_deny <= op_deny;
            end
        end
    end

    assign FL_REQ = state == ST_LOAD || state == ST_OP;
    assign FL_CMD = state == ST_LOAD ? FRG_READ : op_cmd;
    assign FL_ADDR = state == ST_LOAD ? ld_addr : op_addr;
    assign FL_WDATA = op_wdata;
    assign PAR_ACK = state == ST_ANS && !op_cpu && !op_deny;
    assign PAR_DENY = state == ST_ANS && !op_cpu && op_deny;
    assign PAR_RDATA = op_rdata;

    ////////////////////////////////////////////////////////////////////////
    // serial link, clocked variant; the unclocked variant is left to software
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;
    logic [7:0] tx_shift;
    logic [LDW-1:0] id_cnt;
    logic id_bad;
    logic rx_valid;
    logic wr_pend;
    logic [7:0] wr_off;
    wire ser_rise = serial_mode && sclk_rise;
    wire byte_done = ser_rise && bit_cnt == FRG_BIT_LAST;
    wire [7:0] rx_byte = {rx_shift[6:0], pin_f[FRG_PIN_SIN]};
    wire id_phase = id_cnt != LDW'(ID_LEN);
    wire id_ok = !id_phase && (blank || !id_bad);
    wire rx_set = byte_done && !id_phase && id_ok;
    wire ahb_go = HSEL && HREADY && HTRANS[FRG_HTRANS_ACT];
    wire ahb_rd = ahb_go && !HWRITE;
    wire rx_take = ahb_rd && HADDR[7:0] == FRG_REG_RX;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 3'h0;
            rx_shift <= 8'h00;
            rx_data <= 8'h00;
            id_cnt <= '0;
            id_bad <= 1'h0;
            rx_valid <= 1'h0;
        end else begin
            if (ser_rise) begin
                bit_cnt <= 3'(bit_cnt + 1'h1);
                rx_shift <= rx_byte;
            end
            if (byte_done && id_phase) begin
                id_cnt <= LDW'(id_cnt + 1'h1);
                id_bad <= id_bad || (rx_byte != id_mem[id_cnt]);
            end
            if (rx_set) begin
                rx_data <= rx_byte;
            end
            rx_valid <= rx_set || (rx_valid && !rx_take);
        end
    end

    // next bit moves out just after the programmer samples on its rising edge
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift <= FRG_BLANK;
        end else if (wr_pend && wr_off == FRG_REG_TX) begin
            tx_shift <= HWDATA[7:0];
        end else if (ser_rise) begin
            tx_shift <= {tx_shift[6:0], 1'h1};
        end
    end
    assign SERIAL_OUT_PIN_O = tx_shift[7];
    assign SERIAL_OUT_PIN_OE_N = !serial_mode;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            BUSY_PIN <= 1'h0;
            PROT_LEVEL <= FRG_LVL_OFF;
        end else begin
            BUSY_PIN <= serial_mode && (state != ST_IDLE || rx_valid || cpu_go);
            PROT_LEVEL <= lvl2 ? FRG_LVL2 : (prot_on ? FRG_LVL1 : FRG_LVL_OFF);
        end
    end
    assign SERIAL_MODE = serial_mode;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, no wait states; only the low address byte is decoded
    wire [9:0] stat = {last_deny, state != ST_IDLE, rx_valid, erase_err, prog_err,
                       id_ok, lvl2, prot_on, serial_mode, state != ST_LOAD};
    logic [31:0] rd_mux;
    always_comb begin
        case (HADDR[7:0])
            FRG_REG_CTRL: rd_mux = {29'h0, cpu_cmd, cpu_go};
            FRG_REG_ADDR: rd_mux = {16'h0, cpu_addr};
            FRG_REG_DATA: rd_mux = {24'h0, op_rdata};
            FRG_REG_STAT: rd_mux = {22'h0, stat};
            FRG_REG_RX: rd_mux = {24'h0, rx_data};
            FRG_REG_TX: rd_mux = {24'h0, tx_shift};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'h0;
            wr_off <= 8'h00;
            HRDATA <= 32'h0;
            cpu_go <= 1'h0;
            cpu_cmd <= FRG_READ;
            cpu_addr <= 16'h0000;
            cpu_wdata <= 8'h00;
        end else begin
            wr_pend <= ahb_go && HWRITE;
            wr_off <= HADDR[7:0];
            HRDATA <= ahb_rd ? rd_mux : 32'h0;
            if (cpu_go && take) begin
                cpu_go <= 1'h0;
            end else if (wr_pend && wr_off == FRG_REG_CTRL && HWDATA[FRG_CTRL_GO] && !cpu_go) begin
                cpu_go <= 1'h1;
                cpu_cmd <= HWDATA[FRG_CTRL_CMD +: 2];
            end
            if (wr_pend && wr_off == FRG_REG_ADDR) begin
                cpu_addr <= HWDATA[15:0];
            end
            if (wr_pend && wr_off == FRG_REG_DATA) begin
                cpu_wdata <= HWDATA[7:0];
            end
        end
    end
    assign HREADYOUT = 1'h1;
    assign HRESP = 1'h0;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!rst_n);

    property p_prot_mod;
        par_take && prot_on && (PAR_CMD == FRG_PROG || PAR_CMD == FRG_ERASE) |=> PAR_DENY && !FL_REQ;
    endproperty
    a_prot_mod: assert property (p_prot_mod) else $error("modify passed while protected");
    property p_lvl2;
        state != ST_LOAD && l1_sel && l2_sel && !rel_off |=> PROT_LEVEL == FRG_LVL2;
    endproperty
    a_lvl2: assert property (p_lvl2) else $error("level 2 not applied");
    property p_test_rd;
        par_take && lvl2 && PAR_TEST && PAR_CMD == FRG_READ |=> PAR_DENY ##1 !PAR_ACK;
    endproperty
    a_test_rd: assert property (p_test_rd) else $error("test read passed at level 2");
    property p_rel_off;
        par_take && rel_off && PAR_CMD == FRG_READ && !serial_mode && !err_any
            |=> FL_REQ && FL_CMD == FRG_READ && FL_ADDR == $past(PAR_ADDR);
    endproperty
    a_rel_off: assert property (p_rel_off) else $error("read refused with protection off");
    property p_rel_lock;
        par_take && prot_on && PAR_CMD == FRG_PROG && PAR_ADDR == FRG_PROT_ADDR |=> PAR_DENY;
    endproperty
    a_rel_lock: assert property (p_rel_lock) else $error("release bits rewritten");
    property p_id_gate;
        $rose(rx_valid) |-> $past(id_ok) && $past(serial_mode);
    endproperty
    a_id_gate: assert property (p_id_gate) else $error("byte passed without identifier");
    property p_boot_ser;
        state == ST_OP && serial_mode && FL_CMD != FRG_READ |-> !in_boot(FL_ADDR);
    endproperty
    a_boot_ser: assert property (p_boot_ser) else $error("boot write in serial mode");
    property p_boot_erase;
        take && erase_boot && !take_deny |=> FL_REQ && FL_ADDR == FRG_BOOT_LO;
    endproperty
    a_boot_erase: assert property (p_boot_erase) else $error("boot erase not whole block");
    property p_err_ref;
        par_take && err_any && PAR_CMD != FRG_CLEAR |=> PAR_DENY ##1 state == ST_IDLE;
    endproperty
    a_err_ref: assert property (p_err_ref) else $error("command taken with error flag");
    property p_busy;
        state == ST_OP && serial_mode |=> BUSY_PIN;
    endproperty
    a_busy: assert property (p_busy) else $error("busy low during operation");
    property p_strap;
        $rose(serial_mode) |-> $past(strap_ok) && $past(state) == ST_LOAD;
    endproperty
    a_strap: assert property (p_strap) else $error("serial mode without straps");
    property p_load;
        PAR_ACK |-> $past(state, 2) != ST_LOAD;
    endproperty
    a_load: assert property (p_load) else $error("request served before load");
    c_rx: cover property ($rose(rx_valid));
    c_deny: cover property (PAR_DENY);
    c_ack: cover property (PAR_ACK);
    c_boot: cover property (FL_REQ && FL_CMD == FRG_ERASE && FL_ADDR == FRG_BOOT_LO);
endmodule : frg_guard

//--- tb/frg_flash_model.sv
`timescale 1ns/1ps
module frg_flash_model
    import frg_pkg::*;
(
    input wire logic clk,
    input wire logic req,
    input wire logic [1:0] cmd,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    output logic done,
    output logic [7:0] rdata,
    output logic perr,
    output logic eerr
);
    logic [7:0] mem [0:65535];
    logic inj = 1'b0;
    logic [15:0] last_addr = 16'h0000;
    int wait_cnt = 1;
    initial begin
        done = 1'b0;
        rdata = 8'h00;
        perr = 1'b0;
        eerr = 1'b0;
        for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
    end
    ////////////////////////////////////////////////////////////////
    // answer delay varies from prompt to slow; data lines toggle when idle so stale data never looks valid
    always @(posedge clk) begin
        done <= 1'b0;
        perr <= 1'b0;
        eerr <= 1'b0;
        rdata <= ~rdata;
        if (req === 1'b1 && !done) begin
            if (wait_cnt == 0) begin
                done <= 1'b1;
                rdata <= mem[addr];
                last_addr <= addr;
                perr <= inj && cmd == FRG_PROG;
                eerr <= inj && cmd == FRG_ERASE;
                if (cmd == FRG_PROG) mem[addr] <= wdata;
                wait_cnt <= $urandom_range(2, 0);
            end else begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule : frg_flash_model

//--- tb/frg_guard_tb.sv
`timescale 1ns/1ps
module frg_guard_tb;
    import frg_pkg::*;
    logic CLK = 1'b0, RESET_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, PAR_REQ = 1'b0, PAR_TEST = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
    logic [1:0] HTRANS = 2'h0, PAR_CMD = 2'h0;
    logic [15:0] PAR_ADDR = 16'h0;
    logic [7:0] PAR_WDATA = 8'h0;
    logic boot_sel = 1'b0, rp_in = 1'b1, sclk = 1'b0, sin = 1'b0, sout_strap = 1'b1, ce_in = 1'b1;
    logic [7:0] id [7];
    int miscompares = 0, num_checks = 0;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, sout_i, sout_o, sout_oe_n, busy, smode, pack, pdeny, fl_req, fl_done, fl_perr, fl_eerr;
    wire logic [1:0] plvl, fl_cmd;
    wire logic [7:0] prdata, fl_wdata, fl_rdata;
    wire logic [15:0] fl_addr;
    // released line sits at its pull-up level
    assign sout_i = sout_oe_n ? sout_strap : sout_o;
    always #25 CLK = ~CLK;
    frg_guard dut (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .BOOT_SELECT_PIN(boot_sel), .REWRITE_PROTECT_INPUT(rp_in), .CHIP_ENABLE_INPUT(ce_in),
        .SERIAL_CLOCK_PIN(sclk), .SERIAL_IN_PIN(sin), .SERIAL_OUT_PIN_I(sout_i), .SERIAL_OUT_PIN_O(sout_o),
        .SERIAL_OUT_PIN_OE_N(sout_oe_n), .BUSY_PIN(busy), .SERIAL_MODE(smode), .PROT_LEVEL(plvl),
        .PAR_REQ(PAR_REQ), .PAR_CMD(PAR_CMD), .PAR_ADDR(PAR_ADDR), .PAR_WDATA(PAR_WDATA), .PAR_TEST(PAR_TEST),
        .PAR_ACK(pack), .PAR_DENY(pdeny), .PAR_RDATA(prdata), .FL_REQ(fl_req), .FL_CMD(fl_cmd),
        .FL_ADDR(fl_addr), .FL_WDATA(fl_wdata), .FL_DONE(fl_done), .FL_RDATA(fl_rdata),
        .FL_PROG_ERR(fl_perr), .FL_ERASE_ERR(fl_eerr));
    frg_flash_model fm (.clk(CLK), .req(fl_req), .cmd(fl_cmd), .addr(fl_addr), .wdata(fl_wdata),
        .done(fl_done), .rdata(fl_rdata), .perr(fl_perr), .eerr(fl_eerr));
    ////////////////////////////////////////////////////////////////
    function automatic logic [1:0] exp_lvl(input logic [7:0] c);
        if (c[7:6] == FRG_REL_OFF) return FRG_LVL_OFF;
        return !c[FRG_L2_BIT] ? FRG_LVL2 : (!c[FRG_L1_BIT] ? FRG_LVL1 : FRG_LVL_OFF);
    endfunction : exp_lvl
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task automatic rst(input logic [7:0] c, input logic ser);
        int n;
        n = 0;
        for (int i = 0; i < 7; i++) fm.mem[FRG_ID_ADDR + i] = id[i];
        fm.mem[FRG_PROT_ADDR] = c;
        boot_sel <= ser;
        rp_in <= !ser;
        RESET_N <= 1'b0;
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (4) @(posedge CLK);
        while (fl_req !== 1'b0 && n++ < 200) @(posedge CLK);
        repeat (2) @(posedge CLK);
        chk(fl_req, 1'b0);
        chk(smode, ser && ce_in);
        chk(sout_oe_n, !(ser && ce_in));
        chk(plvl, exp_lvl(c));
    endtask : rst
    task automatic par(input logic [1:0] c, input logic [15:0] a, input logic t, input logic dn);
        int n;
        n = 0;
        PAR_REQ <= 1'b1;
        PAR_CMD <= c;
        PAR_ADDR <= a;
        PAR_TEST <= t;
        PAR_WDATA <= 8'($urandom);
        do @(posedge CLK); while (pack !== 1'b1 && pdeny !== 1'b1 && n++ < 100);
        PAR_REQ <= 1'b0;
        chk(pack | pdeny, 1'b1);
        chk(pdeny, dn);
        if (pack === 1'b1 && c == FRG_READ) chk(prdata, fm.mem[a]);
        @(posedge CLK);
    endtask : par
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        do @(posedge CLK); while (hreadyout !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (hreadyout !== 1'b1);
        r = hrdata;
        chk(hresp, 1'b0);
    endtask : ahb
    // link clock only runs within a byte; sample our output bit just before each rising edge
    task automatic ser(input logic [7:0] b, output logic [7:0] g);
        for (int i = 7; i >= 0; i--) begin
            sin <= b[i];
            repeat (4) @(posedge CLK);
            g[i] = sout_o;
            sclk <= 1'b1;
            repeat (4) @(posedge CLK);
            sclk <= 1'b0;
        end
        repeat (8) @(posedge CLK);
    endtask : ser
    ////////////////////////////////////////////////////////////////
    initial begin
        #1ms;
        miscompares++;
        final_report();
    end
    initial begin
        logic [7:0] c, g;
        logic [31:0] r;
        logic [1:0] lv;
        logic t;
        int n;
        void'($urandom(93));
        // the flash image fills itself at time zero; preload only after that
        @(posedge CLK);
        for (int i = 0; i < 7; i++) id[i] = 8'($urandom);
        for (int k = 0; k < 6; k++) begin
            c = (k == 0) ? 8'hF3 : (k == 1) ? 8'hFB : (k == 2) ? 8'h33 : 8'($urandom);
            rst(c, 1'b0);
            lv = exp_lvl(c);
            t = (k < 2) ? 1'b1 : 1'($urandom);
            par(FRG_READ, 16'($urandom_range(32767)), t, lv != 0 && !(t && lv == FRG_LVL1));
            par(FRG_PROG, lv != 0 ? FRG_PROT_ADDR : {8'h01, 8'(k)}, 1'b0, lv != 0);
        end
        rst(8'h3F, 1'b0);
        fm.inj = 1'b1;
        par(FRG_PROG, 16'h0200, 1'b0, 1'b0);
        fm.inj = 1'b0;
        par(FRG_READ, 16'h0200, 1'b0, 1'b1);
        par(FRG_CLEAR, 16'h0000, 1'b0, 1'b0);
        par(FRG_READ, 16'h0200, 1'b0, 1'b0);
        par(FRG_ERASE, 16'hF123, 1'b0, 1'b0);
        chk(fm.last_addr, FRG_BOOT_LO);
        rst(8'h3F, 1'b1);
        c = 8'($urandom);
        ahb(1'b1, FRG_REG_TX, {24'h0, c}, r);
        repeat (4) @(posedge CLK);
        for (int i = 0; i < 7; i++) begin
            ser(id[i], g);
            if (i == 0) chk(g, c);
        end
        c = 8'($urandom);
        ser(c, g);
        chk(busy, 1'b1);
        ahb(1'b0, FRG_REG_RX, 32'h0, r);
        chk(r[7:0], c);
        for (int k = 0; k < 2; k++) begin
            ahb(1'b1, FRG_REG_ADDR, k ? 32'h0100 : 32'hF000, r);
            ahb(1'b1, FRG_REG_CTRL, 32'h3, r);
            repeat (4) @(posedge CLK);
            n = 0;
            do ahb(1'b0, FRG_REG_STAT, 32'h0, r); while (r[8] !== 1'b0 && n++ < 50);
            chk(r[8], 1'b0);
            chk(r[9], k == 0);
        end
        // chip enable low spoils the straps: no serial mode
        ce_in <= 1'b0;
        rst(8'h3F, 1'b1);
        ce_in <= 1'b1;
        rst(8'h3F, 1'b1);
        for (int i = 0; i < 8; i++) ser(i == 3 ? ~id[3] : id[i % 7], g);
        chk(busy, 1'b0);
        ahb(1'b0, FRG_REG_STAT, 32'h0, r);
        chk(r[7], 1'b0);
        chk(r[4], 1'b0);
        par(FRG_READ, 16'h0100, 1'b0, 1'b1);
        final_report();
    end
endmodule : frg_guard_tb
